// ===== logic/ctb_tx_buffer_control.sv
`timescale 1ns/100ps

//Contract
// - init mode holds these registers in reset
// - writes only outside init; reads always
// - empty interrupt only when its enable set
// - abort granted before start or after failure
// - abort sets empty and acknowledge, may interrupt
// - software cannot clear an abort request
// - abort request cleared when empty sets
// - acknowledge bits read only
// - acknowledge cleared when empty cleared
// - acknowledge one means aborted, zero sent
// - lowest set select bit maps the window
// - select reads back lowest set bit only
// - window blocked while buffer is queued
// - no selection means no window access
// - write one clears empty, queues buffer
// - successful send sets empty flag
// - listen mode blocks clearing and sending
module ctb_tx_buffer_control
   import ctb_pkg::*;
(
   input  wire logic            aclk,
   input  wire logic            aresetn,
   input  wire logic [AW-1:0]   s_axi_awaddr,
   input  wire logic [2:0]      s_axi_awprot,
   input  wire logic            s_axi_awvalid,
   output logic                 s_axi_awready,
   input  wire logic [DW-1:0]   s_axi_wdata,
   input  wire logic [DW/8-1:0] s_axi_wstrb,
   input  wire logic            s_axi_wvalid,
   output logic                 s_axi_wready,
   output logic [1:0]           s_axi_bresp,
   output logic                 s_axi_bvalid,
   input  wire logic            s_axi_bready,
   input  wire logic [AW-1:0]   s_axi_araddr,
   input  wire logic [2:0]      s_axi_arprot,
   input  wire logic            s_axi_arvalid,
   output logic                 s_axi_arready,
   output logic [DW-1:0]        s_axi_rdata,
   output logic [1:0]           s_axi_rresp,
   output logic                 s_axi_rvalid,
   input  wire logic            s_axi_rready,
   input  wire logic            init_mode_request,
   input  wire logic            init_mode_ack,
   input  wire logic            listen_mode,
   input  wire ctb_buf_t        tx_sent_ok,
   input  wire ctb_buf_t        tx_busy,
   input  wire ctb_buf_t        tx_failed,
   input  wire logic            window_access,
   output ctb_buf_t             buffer_empty_flag,
   output ctb_buf_t             send_queue_q,
   output ctb_buf_t             window_select_q,
   output logic                 window_grant_q,
   output logic                 send_irq_q
);

   // ----------------------------------------------------------------
   // mode decode
   // ----------------------------------------------------------------
   logic hold_init;
   logic write_ok;

   assign hold_init = init_mode_request & init_mode_ack;
   assign write_ok  = ~init_mode_request & ~init_mode_ack;

   // ----------------------------------------------------------------
   // write channel: address and data taken in either order
   // ----------------------------------------------------------------
   logic [AW-1:0]   aw_addr_q;
   logic            aw_have_q;
   logic [DW-1:0]   w_data_q;
   logic            w_lane0_q;
   logic            w_have_q;
   logic            wr_fire;
   logic            wr_hit;

   assign wr_fire = aw_have_q & w_have_q & ~s_axi_bvalid;

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_have_q     <= 1'b0;
         aw_addr_q     <= '0;
         s_axi_awready <= 1'b0;
      end
      else if (s_axi_awvalid && s_axi_awready)
      begin
         aw_have_q     <= 1'b1;
         aw_addr_q     <= s_axi_awaddr;
         s_axi_awready <= 1'b0;
      end
      else if (wr_fire)
      begin
         aw_have_q     <= 1'b0;
         s_axi_awready <= 1'b0;
      end
      else
         s_axi_awready <= ~aw_have_q & ~s_axi_bvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         w_have_q     <= 1'b0;
         w_data_q     <= '0;
         w_lane0_q    <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else if (s_axi_wvalid && s_axi_wready)
      begin
         w_have_q     <= 1'b1;
         w_data_q     <= s_axi_wdata;
         w_lane0_q    <= s_axi_wstrb[0];
         s_axi_wready <= 1'b0;
      end
      else if (wr_fire)
      begin
         w_have_q     <= 1'b0;
         s_axi_wready <= 1'b0;
      end
      else
         s_axi_wready <= ~w_have_q & ~s_axi_bvalid;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OKAY;
      end
      else if (wr_fire)
      begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_bready)
         s_axi_bvalid <= 1'b0;
   end

   // ----------------------------------------------------------------
   // write decode; only byte lane 0 carries register bits
   // ----------------------------------------------------------------
   logic     wr_empty;
   logic     wr_ier;
   logic     wr_abort;
   logic     wr_sel;
   ctb_buf_t wr_bits;

   assign wr_bits = w_data_q[NBUF-1:0];

   always_comb
   begin
      wr_empty = 1'b0;
      wr_ier   = 1'b0;
      wr_abort = 1'b0;
      wr_sel   = 1'b0;
      wr_hit   = 1'b1;
      if (aw_addr_q == ctb_byte_addr(IDX_EMPTY_FLAGS))
         wr_empty = 1'b1;
      else if (aw_addr_q == ctb_byte_addr(IDX_IRQ_ENABLE))
         wr_ier = 1'b1;
      else if (aw_addr_q == ctb_byte_addr(IDX_ABORT_REQ))
         wr_abort = 1'b1;
      else if (aw_addr_q == ctb_byte_addr(IDX_BUF_SELECT))
         wr_sel = 1'b1;
      else if (aw_addr_q != ctb_byte_addr(IDX_ABORT_ACK))
         wr_hit = 1'b0;
   end

   // writes that are allowed to land this cycle
   logic     commit;
   ctb_buf_t empty_clr_wr;
   ctb_buf_t abort_set_wr;

   assign commit       = wr_fire & w_lane0_q & write_ok;
   assign empty_clr_wr = (commit && wr_empty) ? wr_bits : RST_ZERO;
   assign abort_set_wr = (commit && wr_abort) ? wr_bits : RST_ZERO;

   // ----------------------------------------------------------------
   // enable and select registers
   // ----------------------------------------------------------------
   ctb_buf_t ier_q;
   ctb_buf_t sel_q;
   ctb_buf_t sel_low;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_init)
         ier_q <= RST_ZERO;
      else if (commit && wr_ier)
         ier_q <= wr_bits;
   end

   // the raw bits are kept; only the lowest set one takes effect
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_init)
         sel_q <= RST_ZERO;
      else if (commit && wr_sel)
         sel_q <= wr_bits;
   end

   assign sel_low = ctb_lowest(sel_q);

   // ----------------------------------------------------------------
   // per-buffer state
   // ----------------------------------------------------------------
   ctb_buf_t empty_flags;
   ctb_buf_t abort_req;
   ctb_buf_t abort_ack;

   for (genvar i = 0; i < NBUF; i++)
   begin : g_slot
      ctb_buffer_slot u_slot (
         .aclk         (aclk),
         .aresetn      (aresetn),
         .hold_init    (hold_init),
         .empty_clr_wr (empty_clr_wr[i]),
         .abort_set_wr (abort_set_wr[i]),
         .listen_mode  (listen_mode),
         .sent_ok      (tx_sent_ok[i]),
         .tx_busy      (tx_busy[i]),
         .tx_failed    (tx_failed[i]),
         .empty_q      (empty_flags[i]),
         .abort_req_q  (abort_req[i]),
         .abort_ack_q  (abort_ack[i])
      );
   end

   assign buffer_empty_flag = empty_flags;

   // ----------------------------------------------------------------
   // read channel; one read in flight, answer one cycle after accept
   // ----------------------------------------------------------------
   ctb_buf_t rd_bits;
   logic     rd_hit;

   always_comb
   begin
      rd_bits = RST_ZERO;
      rd_hit  = 1'b1;
      if (s_axi_araddr == ctb_byte_addr(IDX_EMPTY_FLAGS))
         rd_bits = empty_flags;
      else if (s_axi_araddr == ctb_byte_addr(IDX_IRQ_ENABLE))
         rd_bits = ier_q;
      else if (s_axi_araddr == ctb_byte_addr(IDX_ABORT_REQ))
         rd_bits = abort_req;
      else if (s_axi_araddr == ctb_byte_addr(IDX_ABORT_ACK))
         rd_bits = abort_ack;
      else if (s_axi_araddr == ctb_byte_addr(IDX_BUF_SELECT))
         rd_bits = sel_low;
      else
         rd_hit = 1'b0;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= '0;
         s_axi_rresp   <= RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= {{(DW-NBUF){1'b0}}, rd_bits};
         s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
      else if (s_axi_rvalid)
      begin
         s_axi_arready <= 1'b0;
         if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
      end
      else
         s_axi_arready <= 1'b1;
   end

   // ----------------------------------------------------------------
   // transmit window and engine hand-off
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         window_select_q <= RST_ZERO;
         window_grant_q  <= 1'b0;
         send_queue_q    <= RST_ZERO;
      end
      else
      begin
         window_select_q <= sel_low;
         // queued buffers are shut out, as is an empty selection
         window_grant_q  <= window_access && |(sel_low & empty_flags);
         send_queue_q    <= listen_mode ? RST_ZERO : ~empty_flags;
      end
   end

   // ----------------------------------------------------------------
   // transmit interrupt: level, follows flags and enables
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         send_irq_q <= 1'b0;
      else
         send_irq_q <= |(empty_flags & ier_q);
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   sequence s_abort_write;
      commit && wr_abort;
   endsequence

   a_init_clears: assert property (@(posedge aclk) disable iff (!aresetn)
      hold_init |=> (ier_q == RST_ZERO && sel_q == RST_ZERO && abort_req == RST_ZERO
                     && abort_ack == RST_ZERO))
      else $error("init mode left a register out of reset");

   a_init_no_write: assert property (@(posedge aclk) disable iff (!aresetn)
      (!write_ok && !hold_init) |=> $stable(ier_q))
      else $error("enable register changed during init transition");

   a_irq_gate: assert property (@(posedge aclk) disable iff (!aresetn)
      ##1 send_irq_q == |($past(empty_flags) & $past(ier_q)))
      else $error("interrupt disagrees with flags and enables");

   a_sel_readback: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && s_axi_arready && s_axi_araddr == ctb_byte_addr(IDX_BUF_SELECT))
      |=> s_axi_rdata[NBUF-1:0] == ctb_lowest($past(sel_q)))
      else $error("select read back more than the lowest bit");

   a_window_block: assert property (@(posedge aclk) disable iff (!aresetn)
      window_grant_q |-> |($past(sel_low) & $past(empty_flags)))
      else $error("window opened on a queued or unselected buffer");

   a_abort_zero: assert property (@(posedge aclk) disable iff (!aresetn)
      (s_abort_write and (wr_bits == RST_ZERO)) ##0 (!hold_init && tx_sent_ok == RST_ZERO
      && tx_failed == RST_ZERO && (abort_req & ~empty_flags & ~tx_busy) == RST_ZERO)
      |=> $stable(abort_req))
      else $error("zero abort write changed request state");

   a_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
      wr_fire |=> s_axi_bvalid)
      else $error("write not answered the cycle after both halves");

endmodule

// ===== inc/ctb_pkg.sv
package ctb_pkg;

   // ----------------------------------------------------------------
   // geometry
   // ----------------------------------------------------------------
   localparam int unsigned NBUF     = 3;
   localparam int unsigned AW       = 8;
   localparam int unsigned DW       = 32;
   localparam int unsigned REG_W    = 8;

   // ----------------------------------------------------------------
   // register indices; byte address is four times the index
   // ----------------------------------------------------------------
   localparam logic [AW-1:0] IDX_EMPTY_FLAGS = 8'h06;
   localparam logic [AW-1:0] IDX_IRQ_ENABLE  = 8'h07;
   localparam logic [AW-1:0] IDX_ABORT_REQ   = 8'h08;
   localparam logic [AW-1:0] IDX_ABORT_ACK   = 8'h09;
   localparam logic [AW-1:0] IDX_BUF_SELECT  = 8'h0a;
   localparam int unsigned   IDX_SHIFT       = 2;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [NBUF-1:0] RST_EMPTY = 3'h7;
   localparam logic [NBUF-1:0] RST_ZERO  = 3'h0;

   // ----------------------------------------------------------------
   // bus answers
   // ----------------------------------------------------------------
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef logic [NBUF-1:0] ctb_buf_t;

   function automatic logic [AW-1:0] ctb_byte_addr(input logic [AW-1:0] idx);
      ctb_byte_addr = idx << IDX_SHIFT;
   endfunction

   // keeps only the lowest set bit
   function automatic ctb_buf_t ctb_lowest(input ctb_buf_t v);
      ctb_lowest = v & (~v + ctb_buf_t'(1));
   endfunction

endpackage

// ===== logic/ctb_buffer_slot.sv
`timescale 1ns/100ps

module ctb_buffer_slot
   import ctb_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic hold_init,
   input  wire logic empty_clr_wr,
   input  wire logic abort_set_wr,
   input  wire logic listen_mode,
   input  wire logic sent_ok,
   input  wire logic tx_busy,
   input  wire logic tx_failed,
   output logic      empty_q,
   output logic      abort_req_q,
   output logic      abort_ack_q
);

   // ----------------------------------------------------------------
   // events
   // ----------------------------------------------------------------
   logic abort_grant;
   logic empty_set;
   logic empty_clear;

   // granted before the frame starts, or after it lost arbitration / errored
   assign abort_grant = abort_req_q & ~empty_q & (~tx_busy | tx_failed);
   assign empty_set   = (sent_ok & ~empty_q) | abort_grant;
   // set beats clear; listen mode keeps the buffer from being queued
   assign empty_clear = empty_clr_wr & empty_q & ~listen_mode & ~empty_set;

   // ----------------------------------------------------------------
   // empty flag
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_init)
         empty_q <= RST_EMPTY[0];
      else if (empty_set)
         empty_q <= 1'b1;
      else if (empty_clear)
         empty_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // abort request: software can only set it, hardware clears it
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_init)
         abort_req_q <= RST_ZERO[0];
      else if (empty_set)
         abort_req_q <= 1'b0;
      else if (abort_set_wr && !empty_q)
         abort_req_q <= 1'b1;
   end

   // ----------------------------------------------------------------
   // abort acknowledge
   // ----------------------------------------------------------------
   always_ff @(posedge aclk)
   begin
      if (!aresetn || hold_init)
         abort_ack_q <= RST_ZERO[0];
      else if (abort_grant && !sent_ok)
         abort_ack_q <= 1'b1;
      else if (empty_clear || sent_ok)
         abort_ack_q <= 1'b0;
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   a_grant_sets_ack: assert property (@(posedge aclk) disable iff (!aresetn)
      (abort_grant && !sent_ok && !hold_init) |=> (empty_q && abort_ack_q && !abort_req_q))
      else $error("granted abort did not empty and acknowledge");

   a_no_sw_clear: assert property (@(posedge aclk) disable iff (!aresetn)
      (abort_req_q && !empty_set && !hold_init) |=> abort_req_q)
      else $error("abort request dropped without the buffer emptying");

   a_busy_blocks_abort: assert property (@(posedge aclk) disable iff (!aresetn)
      (!empty_q && tx_busy && !tx_failed && !sent_ok && !hold_init) |=> !empty_q)
      else $error("abort granted during a running transmission");

   a_listen_keeps: assert property (@(posedge aclk) disable iff (!aresetn)
      (listen_mode && empty_q && !hold_init) |=> empty_q)
      else $error("empty flag cleared in listen mode");

endmodule

// ===== testbench/can_tx_buffer_control_tb.sv
`timescale 1ns/100ps

module can_tx_buffer_control_tb
   import ctb_pkg::*;
;
   // --------------------------------
   // signals
   // --------------------------------
   logic            aclk, aresetn;
   logic [AW-1:0]   awaddr, araddr;
   logic            awvalid, awready, wvalid, wready, bvalid, bready;
   logic [DW-1:0]   wdata, rdata;
   logic [DW/8-1:0] wstrb;
   logic [1:0]      bresp, rresp;
   logic            arvalid, arready, rvalid, rready;
   logic            init_req, init_ack, listen, win_acc, win_grant, irq;
   ctb_buf_t        sent_ok, busy, failed, empty, queue, win_sel;
   logic [33:0]     rq[$];
   logic [1:0]      bq[$];
   int              fails, total_checks, seed, i;

   localparam logic [AW-1:0] A_EF  = IDX_EMPTY_FLAGS << IDX_SHIFT;
   localparam logic [AW-1:0] A_IE  = IDX_IRQ_ENABLE << IDX_SHIFT;
   localparam logic [AW-1:0] A_AR  = IDX_ABORT_REQ << IDX_SHIFT;
   localparam logic [AW-1:0] A_AK  = IDX_ABORT_ACK << IDX_SHIFT;
   localparam logic [AW-1:0] A_SEL = IDX_BUF_SELECT << IDX_SHIFT;

   ctb_tx_buffer_control i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .init_mode_request(init_req), .init_mode_ack(init_ack),
      .listen_mode(listen), .tx_sent_ok(sent_ok), .tx_busy(busy), .tx_failed(failed),
      .window_access(win_acc), .buffer_empty_flag(empty), .send_queue_q(queue),
      .window_select_q(win_sel), .window_grant_q(win_grant), .send_irq_q(irq)
   );

   always #2 aclk = ~aclk;

   // --------------------------------
   // checking and closing
   // --------------------------------
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         fails++;
      end
   endtask

   task automatic close_out;
      if (fails == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // answers are judged here, in the order their requests were made
   always @(posedge aclk)
   begin
      logic [33:0] e;
      if (rvalid === 1'b1 && rready === 1'b1 && rq.size() > 0)
      begin
         e = rq.pop_front();
         check("rdata", rdata, e[31:0]);
         check("rresp", 32'(rresp), 32'(e[33:32]));
      end
      if (bvalid === 1'b1 && bready === 1'b1 && bq.size() > 0)
         check("bresp", 32'(bresp), 32'(bq.pop_front()));
   end

   initial
   begin
      #(30000 * 4);
      fails++;
      close_out();
   end

   // --------------------------------
   // bus tasks
   // --------------------------------
   task automatic wr(input logic [AW-1:0] a, input logic [2:0] d,
                     input logic [3:0] s = 4'hf, input logic [1:0] eb = RESP_OKAY);
      logic [31:0] r;
      r = $random(seed);
      bq.push_back(eb);
      awaddr  <= a;
      wdata   <= {r[31:3], d};
      wstrb   <= s;
      awvalid <= 1'b1;
      wvalid  <= 1'b1;
      bready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (awvalid && awready)
            awvalid <= 1'b0;
         if (wvalid && wready)
            wvalid <= 1'b0;
      end
      while (!(bvalid && bready));
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [AW-1:0] a, input logic [2:0] e,
                     input logic [1:0] er = RESP_OKAY);
      rq.push_back({er, 29'h0, e});
      araddr  <= a;
      arvalid <= 1'b1;
      rready  <= 1'b1;
      do
      begin
         @(posedge aclk);
         if (arvalid && arready)
            arvalid <= 1'b0;
      end
      while (!(rvalid && rready));
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic settle;
      repeat (3) @(posedge aclk);
   endtask

   function automatic logic [2:0] low3(input logic [2:0] v);
      low3 = v[0] ? 3'h1 : v[1] ? 3'h2 : v[2] ? 3'h4 : 3'h0;
   endfunction

   // --------------------------------
   // scenarios
   // --------------------------------
   initial
   begin
      aclk = 0; aresetn = 0; seed = 37; fails = 0; total_checks = 0;
      awaddr = 0; araddr = 0; awvalid = 0; wvalid = 0; wdata = 0; wstrb = 0;
      bready = 0; arvalid = 0; rready = 0; init_req = 0; init_ack = 0; listen = 0;
      sent_ok = 0; busy = 0; failed = 0; win_acc = 0;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rd(A_EF, 3'h7); rd(A_IE, 3'h0); rd(A_AR, 3'h0); rd(A_AK, 3'h0); rd(A_SEL, 3'h0);
      win_acc <= 1'b1;
      for (i = 1; i < 8; i++)
      begin
         wr(A_SEL, 3'(i));
         rd(A_SEL, low3(3'(i)));
         settle();
         check("window_select_q", 32'(win_sel), 32'(low3(3'(i))));
         check("window_grant_q", 32'(win_grant), 32'h1);
      end
      win_acc <= 1'b0;
      settle();
      check("window_grant_q", 32'(win_grant), 32'h0);
      win_acc <= 1'b1;
      wr(A_SEL, 3'h0);
      settle();
      check("window_grant_q", 32'(win_grant), 32'h0);
      wr(A_EF, 3'h2);
      wr(A_EF, 3'h0);
      rd(A_EF, 3'h5);
      check("buffer_empty_flag", 32'(empty), 32'h5);
      wr(A_SEL, 3'h2);
      settle();
      check("send_queue_q", 32'(queue), 32'h2);
      check("window_grant_q", 32'(win_grant), 32'h0);
      wr(A_IE, 3'h2);
      settle();
      check("send_irq_q", 32'(irq), 32'h0);
      wr(A_IE, 3'h5);
      settle();
      check("send_irq_q", 32'(irq), 32'h1);
      busy <= 3'h2;
      wr(A_AR, 3'h2);
      rd(A_AR, 3'h2);
      settle();
      rd(A_EF, 3'h5);
      wr(A_AR, 3'h0);
      rd(A_AR, 3'h2);
      wr(A_IE, 3'h2);
      failed <= 3'h2;
      @(posedge aclk);
      failed <= 3'h0;
      settle();
      check("send_irq_q", 32'(irq), 32'h1);
      rd(A_EF, 3'h7); rd(A_AK, 3'h2); rd(A_AR, 3'h0);
      wr(A_AK, 3'h0);
      rd(A_AK, 3'h2);
      wr(A_EF, 3'h2);
      rd(A_AK, 3'h0);
      wr(A_AR, 3'h2);
      sent_ok <= 3'h2;
      @(posedge aclk);
      sent_ok <= 3'h0;
      settle();
      rd(A_EF, 3'h7); rd(A_AR, 3'h0); rd(A_AK, 3'h0);
      busy <= 3'h0;
      wr(A_AR, 3'h1);
      rd(A_AR, 3'h0);
      wr(A_EF, 3'h4);
      wr(A_AR, 3'h4);
      settle();
      rd(A_EF, 3'h7); rd(A_AK, 3'h4);
      listen <= 1'b1;
      wr(A_EF, 3'h1);
      rd(A_EF, 3'h7);
      settle();
      check("send_queue_q", 32'(queue), 32'h0);
      listen <= 1'b0;
      wr(A_IE, 3'h7, 4'he);
      rd(A_IE, 3'h2);
      wr(A_EF, 3'h1);
      rd(A_EF, 3'h6);
      wr(A_SEL, 3'h6);
      rd(A_SEL, 3'h2);
      init_req <= 1'b1;
      settle();
      wr(A_IE, 3'h7);
      rd(A_IE, 3'h2);
      init_ack <= 1'b1;
      settle();
      rd(A_IE, 3'h0); rd(A_SEL, 3'h0); rd(A_AK, 3'h0); rd(A_EF, 3'h7);
      wr(A_SEL, 3'h1);
      rd(A_SEL, 3'h0);
      init_req <= 1'b0;
      init_ack <= 1'b0;
      settle();
      wr(8'h3c, 3'h1, 4'hf, RESP_SLVERR);
      rd(8'h3c, 3'h0, RESP_SLVERR);
      settle();
      close_out();
   end
endmodule
